// ### verilog/lmc_mission_ctrl.sv
// mission control and status registers of the temperature logger
// Summary of operation
// - configuration bits 7 and 6 always read one
// - configuration writes discarded while mission runs
// - alarm start: convert, log only after alarm
// - alarming sample logged first, waits not counted
// - wrap enabled: full log restarts at base
// - wrap disabled: full log stops conversions, mission stays
// - wide format stores msb then lsb
// - logging enabled, samples start at log base
// - alarm status read-only with fixed bits
// - clear memory clears high and low alarm flags, not battery loss
// - battery loss flag set by power-on reset
// - high flag when result at/above high threshold
// - low flag when result at/below low threshold
// - general status read-only with fixed bits
// - awaiting alarm set on start, cleared by alarm
// - clear memory sets cleared flag, start resets it
// - start refused unless memory cleared
// - mission active from start until stop
// - alarmed device answers conditional search
// - alarm enables gate flag setting
// - comparison uses result msb only
// - start delay expires before alarm testing
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lmc_mission_ctrl
    import lmc_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    output var  logic [31:0]       readdata,
    output      logic              waitrequest,
    // mission timing and conversion engine
    input  wire logic              delay_expired,
    input  wire logic              sample_tick,
    input  wire lmc_conv_s         conv,
    output var  logic              conv_request,
    // log memory and counters
    output var  lmc_log_s          log_wr,
    output var  logic              sample_count_inc,
    output var  logic              stamp_capture,
    output var  logic              counters_clear,
    // bus side
    output      logic              search_alarm_match
);
    lmc_state_e  state;
    lmc_state_e  next_state;
    logic [7:0]  mcfg;
    logic [7:0]  sens_ctl;
    logic [7:0]  low_th;
    logic [7:0]  high_th;
    logic        battery_loss_flag;
    logic        high_temp_flag;
    logic        low_temp_flag;
    logic        awaiting_alarm_start;
    logic        memory_cleared_flag;
    logic        mission_active;
    logic        served;
    logic        pending;
    logic        pending_forced;
    logic        lsb_due;
    logic [7:0]  lsb_hold;
    logic [12:0] ptr;
    logic        stamped;

    // bus decode
    wire [IDX_W-1:0] idx     = address[ADDR_W-1:2];
    wire             req     = read | write;
    wire             wr_fire = write & served;
    wire             wr_cfg  = wr_fire & (idx == IDX_MCFG);
    wire             wr_cmd  = wr_fire & (idx == IDX_CMD);
    wire             wr_sens = wr_fire & (idx == IDX_SENS_CTL);
    wire             wr_lth  = wr_fire & (idx == IDX_LOW_TH);
    wire             wr_hth  = wr_fire & (idx == IDX_HIGH_TH);
    wire             cmd_start = wr_cmd & writedata[CMD_START];
    wire             cmd_stop  = wr_cmd & writedata[CMD_STOP];
    wire             cmd_clear = wr_cmd & writedata[CMD_CLEAR] & ~mission_active;
    wire             cmd_force = wr_cmd & writedata[CMD_FORCE] & ~mission_active;
    // a start is refused while running or before memory was cleared
    wire             start_ok  = cmd_start & ~mission_active & memory_cleared_flag;
    wire             in_log    = (state == ST_LOG);
    wire             in_wait   = (state == ST_WAIT);

    // one wait state: readdata is loaded in the first cycle
    assign waitrequest = req & ~served;

    wire [7:0] alarm_rd = AL_FIXED_ONE | {battery_loss_flag, 5'h00, high_temp_flag,
                                          low_temp_flag};
    wire [7:0] state_rd = ST_FIXED_ONE | {3'h0, awaiting_alarm_start,
                                          memory_cleared_flag, 1'b0, mission_active,
                                          1'b0};
    logic [7:0] rd_mux;
    always_comb begin
        case (idx)
            IDX_MCFG:     rd_mux = mcfg | MC_FIXED_ONE;
            IDX_ALARM:    rd_mux = alarm_rd;
            IDX_STATE:    rd_mux = state_rd;
            IDX_SENS_CTL: rd_mux = sens_ctl;
            IDX_LOW_TH:   rd_mux = low_th;
            IDX_HIGH_TH:  rd_mux = high_th;
            default:      rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            served   <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            served <= req & ~served;
            if (read & ~served) begin
                readdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mcfg     <= MC_RESET;
            sens_ctl <= 8'h00;
            low_th   <= 8'h00;
            high_th  <= 8'h00;
        end else begin
            if (wr_cfg & ~mission_active) begin
                mcfg <= writedata[7:0] | MC_FIXED_ONE;
            end
            if (wr_sens & ~mission_active) begin
                sens_ctl <= writedata[7:0] & SC_MASK;
            end
            if (wr_lth & ~mission_active) begin
                low_th <= writedata[7:0];
            end
            if (wr_hth & ~mission_active) begin
                high_th <= writedata[7:0];
            end
        end
    end

    // conversion evaluation
    wire conv_hit   = conv.done & pending;
    wire is_high    = conv.msb >= high_th;
    wire is_low     = conv.msb <= low_th;
    wire any_alarm  = is_high | is_low;
    wire set_high   = conv_hit & is_high & sens_ctl[SC_HIGH_EN];
    wire set_low    = conv_hit & is_low & sens_ctl[SC_LOW_EN];
    wire trig       = conv_hit & ~pending_forced & in_wait & any_alarm;
    // a sample is stored either while logging or for the triggering alarm
    wire store      = conv_hit & ~pending_forced & (in_log | trig)
                      & mcfg[MC_LOG_EN];
    wire wide       = mcfg[MC_WIDTH];
    wire [12:0] step     = wide ? PTR_TWO : PTR_ONE;
    wire [12:0] ptr_next = ptr + step;
    wire        at_end   = wide ? (ptr == PTR_LAST - PTR_ONE) : (ptr == PTR_LAST);
    wire        go_full  = store & at_end & ~mcfg[MC_WRAP];
    wire        conv_go  = sample_tick & (in_log | in_wait) & ~pending;

    // mission state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  if (start_ok) next_state = ST_DELAY;
            ST_DELAY: if (delay_expired) begin
                next_state = mcfg[MC_ALARM_ST] ? ST_WAIT : ST_LOG;
            end
            ST_WAIT:  if (trig) next_state = ST_LOG;
            ST_LOG:   if (go_full) next_state = ST_FULL;
            ST_FULL:  next_state = ST_FULL;
            default:  next_state = ST_IDLE;
        endcase
        if (cmd_stop) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // status flags; a hardware set beats a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            battery_loss_flag    <= 1'b1;
            high_temp_flag       <= 1'b0;
            low_temp_flag        <= 1'b0;
            awaiting_alarm_start <= 1'b0;
            memory_cleared_flag  <= 1'b0;
            mission_active       <= 1'b0;
        end else begin
            if (set_high) begin
                high_temp_flag <= 1'b1;
            end else if (cmd_clear) begin
                high_temp_flag <= 1'b0;
            end
            if (set_low) begin
                low_temp_flag <= 1'b1;
            end else if (cmd_clear) begin
                low_temp_flag <= 1'b0;
            end
            if (start_ok) begin
                awaiting_alarm_start <= mcfg[MC_ALARM_ST];
            end else if (conv_hit & any_alarm & (in_wait | pending_forced)) begin
                awaiting_alarm_start <= 1'b0;
            end
            if (cmd_clear) begin
                memory_cleared_flag <= 1'b1;
            end else if (start_ok) begin
                memory_cleared_flag <= 1'b0;
            end
            if (start_ok) begin
                mission_active <= 1'b1;
            end else if (cmd_stop) begin
                mission_active <= 1'b0;
            end
        end
    end

    // conversion requests and log writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pending          <= 1'b0;
            pending_forced   <= 1'b0;
            conv_request     <= 1'b0;
            lsb_due          <= 1'b0;
            lsb_hold         <= 8'h00;
            ptr              <= PTR_ZERO;
            stamped          <= 1'b0;
            log_wr           <= '0;
            sample_count_inc <= 1'b0;
            stamp_capture    <= 1'b0;
            counters_clear   <= 1'b0;
        end else begin
            conv_request     <= conv_go | (cmd_force & ~pending);
            sample_count_inc <= conv_hit & ~pending_forced & in_log;
            stamp_capture    <= store & ~stamped;
            counters_clear   <= cmd_clear;
            log_wr.we        <= 1'b0;
            if (conv_go | (cmd_force & ~pending)) begin
                pending        <= 1'b1;
                pending_forced <= cmd_force;
            end else if (conv.done | cmd_stop) begin
                pending <= 1'b0;
            end
            if (store) begin
                stamped     <= 1'b1;
                log_wr.we   <= 1'b1;
                log_wr.addr <= LOG_BASE + {3'h0, ptr};
                log_wr.data <= conv.msb;
                lsb_hold    <= conv.lsb;
                lsb_due     <= wide;
                // wrapping is plain 13-bit overflow back to the base
                ptr         <= ptr_next;
            end else if (lsb_due) begin
                lsb_due     <= 1'b0;
                log_wr.we   <= 1'b1;
                log_wr.addr <= log_wr.addr + 16'h0001;
                log_wr.data <= lsb_hold;
            end
            if (cmd_clear) begin
                ptr     <= PTR_ZERO;
                stamped <= 1'b0;
            end
        end
    end

    assign search_alarm_match = high_temp_flag | low_temp_flag | battery_loss_flag;

    // checks
    property p_cfg_locked;
        @(posedge clk) disable iff (!arst_n)
        mission_active |=> $stable(mcfg);
    endproperty
    a_cfg_locked: assert property (p_cfg_locked) else $error("config changed in mission");

    property p_cfg_ones;
        @(posedge clk) disable iff (!arst_n)
        mcfg[7:6] == 2'b11;
    endproperty
    a_cfg_ones: assert property (p_cfg_ones) else $error("config top bits not one");

    property p_refuse;
        @(posedge clk) disable iff (!arst_n)
        (cmd_start & ~memory_cleared_flag & ~mission_active) |=> !mission_active;
    endproperty
    a_refuse: assert property (p_refuse) else $error("start accepted without clear");

    property p_start;
        @(posedge clk) disable iff (!arst_n)
        start_ok |=> mission_active && !memory_cleared_flag
                     && awaiting_alarm_start == $past(mcfg[MC_ALARM_ST]);
    endproperty
    a_start: assert property (p_start) else $error("start effects wrong");

    property p_clear;
        @(posedge clk) disable iff (!arst_n)
        (cmd_clear & ~conv_hit) |=> memory_cleared_flag && !high_temp_flag
                                    && !low_temp_flag && counters_clear;
    endproperty
    a_clear: assert property (p_clear) else $error("clear memory incomplete");

    property p_high;
        @(posedge clk) disable iff (!arst_n)
        (conv_hit & sens_ctl[SC_HIGH_EN] & (conv.msb >= high_th)) |=> high_temp_flag;
    endproperty
    a_high: assert property (p_high) else $error("high flag not set");

    property p_low;
        @(posedge clk) disable iff (!arst_n)
        (conv_hit & ~sens_ctl[SC_LOW_EN] & ~cmd_clear) |=> low_temp_flag == $past(low_temp_flag);
    endproperty
    a_low: assert property (p_low) else $error("low flag set while disabled");

    property p_wide;
        @(posedge clk) disable iff (!arst_n)
        (store & wide) |=> log_wr.we
                           ##1 (log_wr.we && log_wr.addr == $past(log_wr.addr) + 16'h0001);
    endproperty
    a_wide: assert property (p_wide) else $error("wide sample not two bytes");

    property p_full;
        @(posedge clk) disable iff (!arst_n)
        (go_full & ~cmd_stop) |=> (state == ST_FULL) && mission_active && !conv_request;
    endproperty
    a_full: assert property (p_full) else $error("full log did not stop");

    property p_base;
        @(posedge clk) disable iff (!arst_n)
        log_wr.we |-> log_wr.addr >= LOG_BASE;
    endproperty
    a_base: assert property (p_base) else $error("log write below base");

    property p_wait_trigger;
        @(posedge clk) disable iff (!arst_n)
        (trig & ~cmd_stop) |=> !awaiting_alarm_start && (state == ST_LOG);
    endproperty
    a_wait_trigger: assert property (p_wait_trigger) else $error("alarm start missed");

    property p_wait_nocount;
        @(posedge clk) disable iff (!arst_n)
        (conv_hit & in_wait) |=> !sample_count_inc;
    endproperty
    a_wait_nocount: assert property (p_wait_nocount) else $error("wait sample counted");

    property p_delay_hold;
        @(posedge clk) disable iff (!arst_n)
        (state == ST_DELAY) |=> !conv_request;
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("conversion during delay");

    c_alarm_start: cover property (@(posedge clk) disable iff (!arst_n) trig);
    c_full:        cover property (@(posedge clk) disable iff (!arst_n) go_full);
    c_wrap:        cover property (@(posedge clk) disable iff (!arst_n)
                                   store & at_end & mcfg[MC_WRAP]);
    c_forced:      cover property (@(posedge clk) disable iff (!arst_n)
                                   conv_hit & pending_forced);
    c_stop_wait:   cover property (@(posedge clk) disable iff (!arst_n)
                                   cmd_stop & in_wait);
endmodule
`default_nettype wire

// ### verilog/lmc_pkg.sv
// constants and types for the logger mission control and status block
package lmc_pkg;
    localparam int          ADDR_W       = 12;
    localparam int          IDX_W        = 10;
    // register indexes; byte address is four times the index
    localparam logic [9:0]  IDX_LOW_TH   = 10'h208;
    localparam logic [9:0]  IDX_HIGH_TH  = 10'h209;
    localparam logic [9:0]  IDX_SENS_CTL = 10'h210;
    localparam logic [9:0]  IDX_MCFG     = 10'h213;
    localparam logic [9:0]  IDX_ALARM    = 10'h214;
    localparam logic [9:0]  IDX_STATE    = 10'h215;
    localparam logic [9:0]  IDX_CMD      = 10'h230;
    // mission configuration fields
    localparam int          MC_LOG_EN    = 0;
    localparam int          MC_WIDTH     = 2;
    localparam int          MC_WRAP      = 4;
    localparam int          MC_ALARM_ST  = 5;
    localparam logic [7:0]  MC_FIXED_ONE = 8'hC0;
    localparam logic [7:0]  MC_RESET     = 8'hC0;
    // sensor control fields
    localparam int          SC_LOW_EN    = 0;
    localparam int          SC_HIGH_EN   = 1;
    localparam logic [7:0]  SC_MASK      = 8'h03;
    // command register bits
    localparam int          CMD_START    = 0;
    localparam int          CMD_STOP     = 1;
    localparam int          CMD_CLEAR    = 2;
    localparam int          CMD_FORCE    = 3;
    // fixed bits of the status registers
    localparam logic [7:0]  AL_FIXED_ONE = 8'h70;
    localparam logic [7:0]  ST_FIXED_ONE = 8'hC0;
    // log memory
    localparam int          LOG_PTR_W    = 13;
    localparam logic [15:0] LOG_BASE     = 16'h1000;
    localparam logic [12:0] PTR_ONE      = 13'h0001;
    localparam logic [12:0] PTR_TWO      = 13'h0002;
    localparam logic [12:0] PTR_LAST     = 13'h1FFF;
    localparam logic [12:0] PTR_ZERO     = 13'h0000;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_DELAY = 5'b00010,
        ST_WAIT  = 5'b00100,
        ST_LOG   = 5'b01000,
        ST_FULL  = 5'b10000
    } lmc_state_e;

    typedef struct packed {
        logic       done;
        logic [7:0] msb;
        logic [7:0] lsb;
    } lmc_conv_s;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  data;
    } lmc_log_s;
endpackage

// ### bench/lmc_conv_model.sv
// behavioural conversion engine answering the block's conversion requests
`timescale 1ns/10ps
`default_nettype none
module lmc_conv_model
    import lmc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // request side
    input  wire logic       conv_request,
    input  wire logic [3:0] lat,
    // value the next conversion returns
    input  wire logic [7:0] msb,
    input  wire logic [7:0] lsb,
    // result
    output var  lmc_conv_s  conv
);
    logic       busy;
    logic [3:0] cnt;

    // result bytes toggle outside the done cycle so stale data never looks valid
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            cnt  <= 4'h0;
            conv <= '0;
        end else begin
            conv.done <= 1'b0;
            conv.msb  <= ~conv.msb;
            conv.lsb  <= ~conv.lsb;
            if (conv_request) begin
                busy <= 1'b1;
                cnt  <= lat;
            end else if (busy && cnt == 4'h0) begin
                busy <= 1'b0;
                conv <= '{1'b1, msb, lsb};
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/test_lmc_mission_ctrl.sv
// self-checking bench for the mission control and status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module test_lmc_mission_ctrl
    import lmc_pkg::*;
;
    logic              clk;
    logic              arst_n;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic              delay_expired;
    logic              sample_tick;
    lmc_conv_s         conv;
    logic              conv_request;
    lmc_log_s          log_wr;
    logic              sample_count_inc;
    logic              stamp_capture;
    logic              counters_clear;
    logic              search_alarm_match;
    logic [7:0]        t_msb;
    logic [7:0]        t_lsb;
    logic [3:0]        lat;
    logic [31:0]       q;
    lmc_log_s          logq[$];
    int                n_errors;
    int                n_checks;
    int                n_req;
    int                n_inc;
    int                n_stamp;
    int                n_clr;
    int                r0;

    lmc_mission_ctrl DUT (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .delay_expired(delay_expired),
        .sample_tick(sample_tick), .conv(conv), .conv_request(conv_request),
        .log_wr(log_wr), .sample_count_inc(sample_count_inc),
        .stamp_capture(stamp_capture), .counters_clear(counters_clear),
        .search_alarm_match(search_alarm_match));

    lmc_conv_model engine (.clk(clk), .arst_n(arst_n), .conv_request(conv_request),
        .lat(lat), .msb(t_msb), .lsb(t_lsb), .conv(conv));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // pulses are registered, so values seen at the edge are the settled ones
    always @(posedge clk) begin
        if (log_wr.we === 1'b1) logq.push_back(log_wr);
        if (conv_request === 1'b1) n_req++;
        if (sample_count_inc === 1'b1) n_inc++;
        if (stamp_capture === 1'b1) n_stamp++;
        if (counters_clear === 1'b1) n_clr++;
    end

    task automatic give_verdict;
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge clk);
        address   <= {idx, 2'b00};
        read      <= ~w;
        write     <= w;
        writedata <= {24'h0, d};
        // only the watchdog ends a wait that never gets an answer
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        `CHK(q, {24'h0, e})
    endtask

    task automatic tick(input logic [7:0] m, input logic [7:0] l, input int w);
        @(posedge clk);
        t_msb       <= m;
        t_lsb       <= l;
        sample_tick <= 1'b1;
        @(posedge clk);
        sample_tick <= 1'b0;
        repeat (w) @(posedge clk);
    endtask

    task automatic mission(input logic [7:0] cfg);
        wr(IDX_CMD, 8'h02);
        wr(IDX_CMD, 8'h04);
        wr(IDX_MCFG, cfg);
        logq = {};
        wr(IDX_CMD, 8'h01);
    endtask

    initial begin
        repeat (95000) @(posedge clk);
        n_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        give_verdict;
    end

    initial begin
        arst_n = 1'b0; address = '0; read = 1'b0; write = 1'b0; writedata = '0;
        delay_expired = 1'b0; sample_tick = 1'b0; t_msb = 8'h00; t_lsb = 8'h00;
        lat = 4'h0; n_errors = 0; n_checks = 0; n_req = 0; n_inc = 0; n_stamp = 0;
        n_clr = 0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rd(IDX_MCFG, 8'hC0);
        rd(IDX_ALARM, 8'hF0);
        rd(IDX_STATE, 8'hC0);
        rd(10'h3FF, 8'h00);
        `CHK(search_alarm_match, 1'b1)
        wr(IDX_MCFG, 8'h00);
        rd(IDX_MCFG, 8'hC0);
        wr(IDX_ALARM, 8'h03);
        wr(IDX_STATE, 8'h3F);
        rd(IDX_ALARM, 8'hF0);
        rd(IDX_STATE, 8'hC0);
        wr(IDX_CMD, 8'h01);
        rd(IDX_STATE, 8'hC0);
        wr(IDX_LOW_TH, 8'h10);
        wr(IDX_HIGH_TH, 8'h80);
        wr(IDX_SENS_CTL, 8'h03);
        // wide format, immediate start, slow engine
        mission(8'h05);
        `CHK(n_clr, 1)
        rd(IDX_STATE, 8'hC2);
        wr(IDX_MCFG, 8'h15);
        rd(IDX_MCFG, 8'hC5);
        delay_expired <= 1'b1;
        lat <= 4'h3;
        tick(8'h40, 8'h60, 10);
        `CHK(logq.size(), 2)
        `CHK(logq[0], lmc_log_s'{1'b1, 16'h1000, 8'h40})
        `CHK(logq[1], lmc_log_s'{1'b1, 16'h1001, 8'h60})
        `CHK(n_stamp, 1)
        `CHK(n_inc, 1)
        lat <= 4'h0;
        tick(8'h80, 8'h00, 6);
        rd(IDX_ALARM, 8'hF2);
        `CHK(logq[2].addr, 16'h1002)
        wr(IDX_CMD, 8'h02);
        rd(IDX_STATE, 8'hC0);
        wr(IDX_CMD, 8'h04);
        rd(IDX_ALARM, 8'hF0);
        rd(IDX_STATE, 8'hC8);
        // alarm-triggered start held back by the start delay
        delay_expired <= 1'b0;
        mission(8'h21);
        rd(IDX_STATE, 8'hD2);
        r0 = n_req;
        tick(8'h08, 8'h00, 6);
        `CHK(n_req, r0)
        delay_expired <= 1'b1;
        tick(8'h50, 8'h00, 6);
        `CHK(logq.size(), 0)
        r0 = n_inc;
        tick(8'h10, 8'h00, 6);
        `CHK(logq.size(), 1)
        `CHK(logq[0], lmc_log_s'{1'b1, 16'h1000, 8'h10})
        `CHK(n_inc, r0)
        rd(IDX_STATE, 8'hC2);
        rd(IDX_ALARM, 8'hF1);
        // awaiting flag survives stop and clear, then forced conversion removes it
        mission(8'h21);
        wr(IDX_CMD, 8'h02);
        rd(IDX_STATE, 8'hD0);
        wr(IDX_CMD, 8'h04);
        rd(IDX_STATE, 8'hD8);
        wr(IDX_HIGH_TH, 8'h02);
        t_msb <= 8'h10;
        wr(IDX_CMD, 8'h08);
        repeat (8) @(posedge clk);
        rd(IDX_STATE, 8'hC8);
        rd(IDX_ALARM, 8'hF3);
        // fill the whole log, first without wrap, then with it
        for (int w = 0; w < 2; w++) begin
            mission(w ? 8'h15 : 8'h05);
            repeat (4096) tick(8'h20, 8'h40, 6);
            `CHK(logq[8191].addr, 16'h2FFF)
            r0 = n_req;
            tick(8'h21, 8'h41, 6);
            `CHK(n_req - r0, w)
            `CHK(logq.size(), w ? 8194 : 8192)
            if (w == 1) `CHK(logq[8192], lmc_log_s'{1'b1, 16'h1000, 8'h21})
            rd(IDX_STATE, 8'hC2);
        end
        // low alarm disabled: a low result must leave its flag alone
        wr(IDX_CMD, 8'h02);
        wr(IDX_CMD, 8'h04);
        wr(IDX_SENS_CTL, 8'h02);
        t_msb <= 8'h10;
        wr(IDX_CMD, 8'h08);
        repeat (8) @(posedge clk);
        rd(IDX_ALARM, 8'hF2);
        give_verdict;
    end
endmodule
`default_nettype wire
